//--- rbp_ctrl.sv
// reset, boot start, target id, flash pin and clock bias control
`timescale 1ns/1ns
module rbp_ctrl import rbp_pkg::*; (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic TARGET_ID_SELECT,
  input wire logic FRAME_SYNC,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [1:0] SPI_RATE_SEL,
  output logic FLASH_SCLK,
  output logic FLASH_SCLK_OE,
  output logic FLASH_DATA_OUT,
  output logic FLASH_DATA_OUT_OE,
  output logic FLASH_CS_N,
  output logic FLASH_CS_N_OE,
  input wire logic FLASH_DATA_IN,
  output logic XTAL_BIAS_EN,
  output logic [7:0] BOOT_DATA,
  output logic BOOT_VALID,
  output logic BOOT_DONE,
  output logic VIDEO_ALIGN
);

  // ------------------------------------------------------------------
  // reset synchroniser
  // ------------------------------------------------------------------
  logic rst_m; // first reset stage
  logic rst_int; // internal reset, asserts at once, releases on a clock

  // assertion is immediate so pins float with no clock running
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rst_m <= 1'h1;
      rst_int <= 1'h1;
    end else if (CE) begin
      rst_m <= 1'h0;
      rst_int <= rst_m;
    end
  end

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic scl_s; // filtered two-wire clock
  logic sda_s; // filtered two-wire data
  logic sel_s; // filtered address strap
  logic fs_s; // filtered frame sync
  logic din_s; // filtered flash data in

  rbp_sync #(.INIT(1'h1)) u_scl (.clk(CLK), .rst(rst_int), .ce(CE),
    .d(SCL), .q(scl_s));
  rbp_sync #(.INIT(1'h1)) u_sda (.clk(CLK), .rst(rst_int), .ce(CE),
    .d(SDA_IN), .q(sda_s));
  rbp_sync #(.INIT(1'h0)) u_sel (.clk(CLK), .rst(rst_int), .ce(CE),
    .d(TARGET_ID_SELECT), .q(sel_s));
  // frame sync buffer is never powered down, only the common enable
  rbp_sync #(.INIT(1'h0)) u_fs (.clk(CLK), .rst(rst_int), .ce(CE),
    .d(FRAME_SYNC), .q(fs_s));
  rbp_sync #(.INIT(1'h1)) u_din (.clk(CLK), .rst(rst_int), .ce(CE),
    .d(FLASH_DATA_IN), .q(din_s));

  // ------------------------------------------------------------------
  // two-wire target
  // ------------------------------------------------------------------
  rbp_tw_state_t tw_state, next_tw_state;
  logic scl_p, sda_p; // previous filtered levels
  logic [7:0] shreg, next_shreg; // received byte
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [2:0] byte_idx, next_byte_idx;
  logic [15:0] reg_addr, next_reg_addr; // register pointer
  logic [7:0] dat_hi, next_dat_hi; // upper data byte
  logic bias, next_bias; // clock bias enable
  logic sda_oe, next_sda_oe;
  logic wr_cfg; // config word written this cycle
  logic [7:0] tid; // active target id
  logic start_c, stop_c, scl_rise, scl_fall;

  // strap picks which identity is acknowledged
  assign tid = sel_s ? TID_HIGH : TID_LOW;
  assign start_c = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c = scl_s & scl_p & ~sda_p & sda_s;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;

  // byte framing, acknowledge and register write
  always_comb begin
    next_tw_state = tw_state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_byte_idx = byte_idx;
    next_reg_addr = reg_addr;
    next_dat_hi = dat_hi;
    next_bias = bias;
    next_sda_oe = sda_oe;
    wr_cfg = 1'h0;
    case (tw_state)
      TW_BITS: begin
        if (scl_rise && bit_cnt != TW_BITS_PER_BYTE) begin
          next_shreg = {shreg[6:0], sda_s};
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (scl_fall && bit_cnt == TW_BITS_PER_BYTE) begin
          // wrong id or read request: stay off the bus until the next start
          if (byte_idx == 3'h0 && shreg != tid) begin
            next_tw_state = TW_IGNORE;
          end else begin
            next_tw_state = TW_ACK;
            next_sda_oe = 1'h1;
            case (byte_idx)
              3'h1: next_reg_addr = {shreg, reg_addr[7:0]};
              3'h2: next_reg_addr = {reg_addr[15:8], shreg};
              3'h3: next_dat_hi = shreg;
              TW_IDX_DATA_LO: begin
                if (reg_addr == CFG_ADDR) begin
                  wr_cfg = 1'h1;
                  next_bias = dat_hi[BIAS_HI_BIT];
                end
              end
              default: ; // address byte or bytes past the word
            endcase
          end
        end
      end
      TW_ACK: begin
        if (scl_fall) begin
          next_sda_oe = 1'h0;
          next_bit_cnt = 4'h0;
          next_tw_state = TW_BITS;
          if (byte_idx != TW_IDX_MAX) begin
            next_byte_idx = byte_idx + 3'h1;
          end
        end
      end
      TW_IDLE, TW_IGNORE: ; // wait for a start
      default: next_tw_state = TW_IDLE;
    endcase
    // start and stop override any byte in flight
    if (start_c) begin
      next_tw_state = TW_BITS;
      next_bit_cnt = 4'h0;
      next_byte_idx = 3'h0;
      next_sda_oe = 1'h0;
    end else if (stop_c) begin
      next_tw_state = TW_IDLE;
      next_sda_oe = 1'h0;
    end
  end

  // two-wire registers
  always_ff @(posedge CLK or posedge rst_int) begin
    if (rst_int) begin
      tw_state <= TW_IDLE;
      scl_p <= 1'h1;
      sda_p <= 1'h1;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      byte_idx <= 3'h0;
      reg_addr <= 16'h0000;
      dat_hi <= 8'h00;
      bias <= BIAS_RESET;
      sda_oe <= 1'h0;
    end else if (CE) begin
      tw_state <= next_tw_state;
      scl_p <= scl_s;
      sda_p <= sda_s;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      reg_addr <= next_reg_addr;
      dat_hi <= next_dat_hi;
      bias <= next_bias;
      sda_oe <= next_sda_oe;
    end
  end

  // ------------------------------------------------------------------
  // boot reader toward the flash
  // ------------------------------------------------------------------
  rbp_bt_state_t bt_state, next_bt_state;
  rbp_spi_pins_t spi, next_spi;
  logic [4:0] half, next_half; // half period in clocks
  logic [4:0] div, next_div;
  logic [31:0] tx, next_tx; // command and address
  logic [5:0] bits, next_bits;
  logic [7:0] rx, next_rx;
  logic [7:0] byte_cnt, next_byte_cnt;
  logic [7:0] bdata, next_bdata;
  logic bvalid, next_bvalid, bdone, next_bdone;
  logic tick; // end of a half period

  // rate select to half period
  function automatic logic [4:0] rate_half(input logic [1:0] sel);
    case (sel)
      RATE_SLOW: rate_half = HALF_SLOW;
      RATE_MID: rate_half = HALF_MID;
      default: rate_half = HALF_FAST;
    endcase
  endfunction

  assign tick = (div == half - 5'h1);

  // flash sequencer; data move on the falling flash clock edge
  always_comb begin
    next_bt_state = bt_state;
    next_spi = spi;
    next_half = half;
    next_div = div;
    next_tx = tx;
    next_bits = bits;
    next_rx = rx;
    next_byte_cnt = byte_cnt;
    next_bdata = bdata;
    next_bvalid = 1'h0;
    next_bdone = bdone;
    if (bt_state == BT_CMD || bt_state == BT_DATA) begin
      next_div = tick ? 5'h00 : div + 5'h01;
    end
    case (bt_state)
      BT_IDLE: begin
        // first clock out of reset: no command from anyone needed
        next_half = rate_half(SPI_RATE_SEL);
        next_tx = {FLASH_READ_CMD, BOOT_ADDR};
        next_spi = '{sclk: 1'h0, mosi: FLASH_READ_CMD[7], cs_n: 1'h0,
          oe: 1'h1};
        next_div = 5'h00;
        next_bits = 6'h00;
        next_bt_state = BT_CMD;
      end
      BT_CMD: begin
        if (tick) begin
          next_spi.sclk = ~spi.sclk;
          if (spi.sclk) begin
            next_tx = {tx[30:0], 1'h0};
            next_spi.mosi = tx[30];
            next_bits = bits + 6'h01;
            if (bits == CMD_LAST_BIT) begin
              next_bits = 6'h00;
              next_bt_state = BT_DATA;
            end
          end
        end
      end
      BT_DATA: begin
        if (tick) begin
          next_spi.sclk = ~spi.sclk;
          if (spi.sclk) begin
            // sampled a full flash clock period after the flash moved it
            next_rx = {rx[6:0], din_s};
            next_bits = bits + 6'h01;
            if (bits == BYTE_LAST_BIT) begin
              next_bits = 6'h00;
              next_bdata = {rx[6:0], din_s};
              next_bvalid = 1'h1;
              next_byte_cnt = byte_cnt + 8'h01;
              if (byte_cnt == BOOT_BYTES - 8'h01) begin
                next_bt_state = BT_DONE;
              end
            end
          end
        end
      end
      BT_DONE: begin
        next_spi.cs_n = 1'h1; // keep select driven high
        next_spi.sclk = 1'h0;
        next_bdone = 1'h1;
      end
      default: next_bt_state = BT_IDLE;
    endcase
  end

  // boot registers; pins float and sequencer rearms in reset
  always_ff @(posedge CLK or posedge rst_int) begin
    if (rst_int) begin
      bt_state <= BT_IDLE;
      spi <= '{sclk: 1'h0, mosi: 1'h0, cs_n: 1'h1, oe: 1'h0};
      half <= HALF_FAST;
      div <= 5'h00;
      tx <= 32'h00000000;
      bits <= 6'h00;
      rx <= 8'h00;
      byte_cnt <= 8'h00;
      bdata <= 8'h00;
      bvalid <= 1'h0;
      bdone <= 1'h0;
    end else if (CE) begin
      bt_state <= next_bt_state;
      spi <= next_spi;
      half <= next_half;
      div <= next_div;
      tx <= next_tx;
      bits <= next_bits;
      rx <= next_rx;
      byte_cnt <= next_byte_cnt;
      bdata <= next_bdata;
      bvalid <= next_bvalid;
      bdone <= next_bdone;
    end
  end

  // ------------------------------------------------------------------
  // frame alignment
  // ------------------------------------------------------------------
  logic fs_p, align, next_align;

  // rising frame sync marks the fixed point of the frame
  always_comb begin
    next_align = fs_s & ~fs_p;
  end

  always_ff @(posedge CLK or posedge rst_int) begin
    if (rst_int) begin
      fs_p <= 1'h0;
      align <= 1'h0;
    end else if (CE) begin
      fs_p <= fs_s;
      align <= next_align;
    end
  end

  // ------------------------------------------------------------------
  // outputs, each straight from a flip-flop except the constant SDA_OUT
  // ------------------------------------------------------------------
  assign SDA_OUT = 1'h0; // open drain only ever pulls low
  assign SDA_OE = sda_oe;
  assign FLASH_SCLK = spi.sclk;
  assign FLASH_DATA_OUT = spi.mosi;
  assign FLASH_CS_N = spi.cs_n;
  assign FLASH_SCLK_OE = spi.oe;
  assign FLASH_DATA_OUT_OE = spi.oe;
  assign FLASH_CS_N_OE = spi.oe;
  assign XTAL_BIAS_EN = bias;
  assign BOOT_DATA = bdata;
  assign BOOT_VALID = bvalid;
  assign BOOT_DONE = bdone;
  assign VIDEO_ALIGN = align;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [4:0] hi_cnt; // cycles the flash clock has been high

  always_ff @(posedge CLK or posedge rst_int) begin
    if (rst_int) begin
      hi_cnt <= 5'h00;
    end else if (CE) begin
      hi_cnt <= spi.sclk ? hi_cnt + 5'h01 : 5'h00;
    end
  end

  AST_TRISTATE: assert property (@(posedge CLK)
    rst_int |-> !FLASH_SCLK_OE && !FLASH_DATA_OUT_OE && !FLASH_CS_N_OE)
    else $error("flash pins driven during reset");
  AST_QUIET: assert property (@(posedge CLK)
    rst_int |-> !SDA_OE && !BOOT_VALID && !BOOT_DONE && XTAL_BIAS_EN)
    else $error("interface not in reset state");
  AST_RST_REL: assert property (@(posedge CLK)
    $fell(rst_int) |-> !$past(RESET) && !$past(rst_m))
    else $error("reset released without synchroniser");
  AST_BOOT: assert property (@(posedge CLK) disable iff (RESET)
    (bt_state == BT_IDLE && !rst_int && CE) |=>
      bt_state == BT_CMD && !FLASH_CS_N && FLASH_CS_N_OE)
    else $error("boot did not start after reset");
  AST_RATE: assert property (@(posedge CLK) disable iff (rst_int)
    (bt_state == BT_IDLE && CE) |=> half == rate_half($past(SPI_RATE_SEL)))
    else $error("flash rate not taken from select");
  AST_HIGH: assert property (@(posedge CLK) disable iff (rst_int)
    $fell(spi.sclk) && bt_state != BT_DONE |-> hi_cnt == half)
    else $error("flash clock high time wrong");
  AST_NACK: assert property (@(posedge CLK) disable iff (rst_int)
    (CE && tw_state == TW_BITS && scl_fall && !start_c && !stop_c &&
     bit_cnt == TW_BITS_PER_BYTE && byte_idx == 3'h0 && shreg != tid)
    |=> !SDA_OE [*2])
    else $error("acknowledged a foreign id");
  AST_ACK: assert property (@(posedge CLK) disable iff (rst_int)
    (CE && tw_state == TW_BITS && scl_fall && !start_c && !stop_c &&
     bit_cnt == TW_BITS_PER_BYTE && byte_idx == 3'h0 && shreg == tid)
    |=> SDA_OE)
    else $error("own id not acknowledged");
  AST_BIAS: assert property (@(posedge CLK) disable iff (rst_int)
    (CE && wr_cfg && !start_c && !stop_c) |=>
      XTAL_BIAS_EN == $past(dat_hi[BIAS_HI_BIT]))
    else $error("bias bit not written");
  AST_ALIGN: assert property (@(posedge CLK) disable iff (rst_int)
    (CE && fs_s && !fs_p) |=> VIDEO_ALIGN)
    else $error("frame sync edge not aligned");

  COV_BOOT: cover property (@(posedge CLK) $rose(BOOT_DONE));
  COV_ACK: cover property (@(posedge CLK) $rose(SDA_OE));
  COV_BIAS: cover property (@(posedge CLK) $fell(XTAL_BIAS_EN));
  COV_ALIGN: cover property (@(posedge CLK) VIDEO_ALIGN);

endmodule // rbp_ctrl

//--- rbp_flash_model.sv
// behavioural serial flash that answers the boot read
`timescale 1ns/1ns
module rbp_flash_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic oe,
  input wire logic [7:0] key,
  output logic miso,
  output logic [31:0] cmd
);
  // ------------------------------------------------------------------
  // frame state
  // ------------------------------------------------------------------
  int cnt; // clock rises seen in this frame
  int bi; // index of the data bit being shifted out
  logic sel; // selected and actually driven by the device
  logic [7:0] dbyte; // byte under transfer

  // undriven pins are not taken as a selection
  assign sel = oe && (cs_n === 1'h0);

  initial begin
    miso = 1'h1;
    cmd = 32'h0;
    cnt = 0;
  end

  // a new frame clears the header
  always @(negedge cs_n) begin
    cnt = 0;
    cmd = 32'h0;
  end

  // header bits are taken on the rising clock, msb first
  always @(posedge sclk) begin
    if (sel && cnt < 32)
      cmd = {cmd[30:0], mosi};
    if (sel)
      cnt = cnt + 1;
  end

  // data changes after the falling clock; idle line floats up
  always @(negedge sclk or posedge cs_n or negedge oe) begin
    if (sel && cnt >= 32) begin
      bi = cnt - 32;
      dbyte = 8'(bi / 8) ^ key;
      miso = dbyte[7 - bi % 8];
    end else begin
      miso = 1'h1; // internal pull-up when released
    end
  end
endmodule // rbp_flash_model

//--- rbp_pkg.sv
// constants and types shared by the reset, boot and pin control block
package rbp_pkg;

  // ------------------------------------------------------------------
  // clock and flash clock rates
  // ------------------------------------------------------------------
  localparam int CLK_KHZ = 125000; // system clock in kHz
  localparam int SPI_SLOW_KHZ = 4500; // slowest flash clock
  localparam int SPI_MID_KHZ = 9000; // middle flash clock
  localparam int SPI_FAST_KHZ = 18000; // fastest flash clock
  // half periods round up so the flash never runs above its rate
  localparam logic [4:0] HALF_SLOW =
    5'((CLK_KHZ + 2 * SPI_SLOW_KHZ - 1) / (2 * SPI_SLOW_KHZ));
  localparam logic [4:0] HALF_MID =
    5'((CLK_KHZ + 2 * SPI_MID_KHZ - 1) / (2 * SPI_MID_KHZ));
  localparam logic [4:0] HALF_FAST =
    5'((CLK_KHZ + 2 * SPI_FAST_KHZ - 1) / (2 * SPI_FAST_KHZ));
  localparam logic [1:0] RATE_SLOW = 2'h0; // rate select codes
  localparam logic [1:0] RATE_MID = 2'h1;

  // ------------------------------------------------------------------
  // two-wire target identity and configuration word
  // ------------------------------------------------------------------
  localparam logic [7:0] TID_LOW = 8'h90; // strap low
  localparam logic [7:0] TID_HIGH = 8'hBA; // strap high
  localparam logic [15:0] CFG_ADDR = 16'h0014; // clock config word
  localparam int BIAS_BIT = 14; // bias enable position in the word
  localparam int BIAS_HI_BIT = BIAS_BIT - 8; // same bit in upper byte
  localparam logic BIAS_RESET = 1'h1; // bias connected after reset
  localparam logic [3:0] TW_BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] TW_IDX_DATA_LO = 3'h4; // last byte of a write
  localparam logic [2:0] TW_IDX_MAX = 3'h5; // saturating byte index

  // ------------------------------------------------------------------
  // boot read from flash
  // ------------------------------------------------------------------
  localparam logic [7:0] FLASH_READ_CMD = 8'h03; // plain read
  localparam logic [23:0] BOOT_ADDR = 24'h000000; // boot image start
  localparam logic [5:0] CMD_LAST_BIT = 6'h1F; // 32 header bits
  localparam logic [5:0] BYTE_LAST_BIT = 6'h07;
  localparam logic [7:0] BOOT_BYTES = 8'h10; // bytes fetched at boot

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {TW_IDLE, TW_BITS, TW_ACK, TW_IGNORE}
    rbp_tw_state_t;
  typedef enum logic [1:0] {BT_IDLE, BT_CMD, BT_DATA, BT_DONE}
    rbp_bt_state_t;
  typedef struct packed {
    logic sclk; // flash clock level
    logic mosi; // data toward the flash
    logic cs_n; // chip select, active low
    logic oe; // drive enable for all three
  } rbp_spi_pins_t;

endpackage

//--- rbp_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module rbp_sync import rbp_pkg::*; #(
  parameter logic INIT = 1'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic d,
  output logic q
);

  // ------------------------------------------------------------------
  // stages
  // ------------------------------------------------------------------
  logic s1; // metastable stage, read only by s2
  logic s2;
  logic s3;
  logic next_q;

  // a change counts only once the two settled stages agree
  always_comb begin
    next_q = (s2 == s3) ? s3 : q;
  end

  // registers, frozen while the enable is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q <= INIT;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

endmodule // rbp_sync

//--- reset_boot_pin_control_bench.sv
// self-checking bench for the reset, boot and pin control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; \
  if ((g) !== (e)) begin \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    mismatches++; \
  end end
module reset_boot_pin_control_bench import rbp_pkg::*; ();
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic clk, reset, ce, tid_sel, fsync, scl, host_sda, sda_in;
  logic sda_out, sda_oe, f_sclk, f_sclk_oe, f_do, f_do_oe;
  logic f_cs_n, f_cs_n_oe, f_di, bias, bvalid, bdone, valign;
  logic [1:0] rate; // flash clock rate select
  logic [7:0] bdata, key; // boot byte and flash pattern key
  logic [31:0] fcmd; // header seen by the flash
  int mismatches, comparisons;

  // open-drain wire: either party may pull it low
  assign sda_in = host_sda & ~sda_oe;

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  rbp_ctrl dut (.CLK(clk), .RESET(reset), .CE(ce),
    .TARGET_ID_SELECT(tid_sel), .FRAME_SYNC(fsync), .SCL(scl),
    .SDA_IN(sda_in), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .SPI_RATE_SEL(rate), .FLASH_SCLK(f_sclk), .FLASH_SCLK_OE(f_sclk_oe),
    .FLASH_DATA_OUT(f_do), .FLASH_DATA_OUT_OE(f_do_oe),
    .FLASH_CS_N(f_cs_n), .FLASH_CS_N_OE(f_cs_n_oe), .FLASH_DATA_IN(f_di),
    .XTAL_BIAS_EN(bias), .BOOT_DATA(bdata), .BOOT_VALID(bvalid),
    .BOOT_DONE(bdone), .VIDEO_ALIGN(valign));

  rbp_flash_model flash (.sclk(f_sclk), .mosi(f_do), .cs_n(f_cs_n),
    .oe(f_cs_n_oe & f_sclk_oe), .key(key), .miso(f_di), .cmd(fcmd));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] exp_byte(input int i);
    return 8'(i) ^ key;
  endfunction

  // half period the block must use for a rate code
  function automatic logic [4:0] exp_half(input logic [1:0] r);
    return r == RATE_SLOW ? HALF_SLOW : r == RATE_MID ? HALF_MID : HALF_FAST;
  endfunction

  // inputs move on the falling edge only
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic summarize();
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
      mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic timeout(input string w);
    $display("ERROR %s expected done seen timeout", w);
    mismatches++;
    summarize();
  endtask

  // one bit with slow clock; the answer is read mid high phase
  task automatic tw_bit(input logic b, output logic seen);
    host_sda = b;
    wt(12);
    scl = 1'h1;
    wt(6);
    seen = sda_oe;
    wt(6);
    scl = 1'h0;
  endtask

  task automatic tw_byte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      tw_bit(v[i], a);
    tw_bit(1'h1, ack);
  endtask

  // start, id, register word, data word, stop
  task automatic tw_write(input logic [7:0] id, input logic [15:0] ra,
      input logic [15:0] d, output logic ack0);
    logic a;
    host_sda = 1'h0;
    wt(12);
    scl = 1'h0;
    tw_byte(id, ack0);
    tw_byte(ra[15:8], a);
    tw_byte(ra[7:0], a);
    tw_byte(d[15:8], a);
    tw_byte(d[7:0], a);
    host_sda = 1'h0;
    wt(12);
    scl = 1'h1;
    wt(12);
    host_sda = 1'h1;
    wt(12);
  endtask

  // reset, release and follow one whole boot read
  task automatic boot_run(input logic [1:0] r);
    int n, hi, t;
    logic meas;
    rate = r;
    key = 8'($urandom);
    reset = 1'h1;
    wt(2);
    `CHK("sclk_oe in reset", 1'h0, f_sclk_oe)
    `CHK("data_oe in reset", 1'h0, f_do_oe)
    `CHK("cs_oe in reset", 1'h0, f_cs_n_oe)
    `CHK("bias in reset", BIAS_RESET, bias)
    `CHK("done in reset", 1'h0, bdone)
    `CHK("sda_oe in reset", 1'h0, sda_oe)
    reset = 1'h0;
    t = 0;
    while (f_cs_n !== 1'h0 && t < 10) begin
      wt(1);
      t++;
    end
    `CHK("cycles to boot start", 3, t)
    if (t >= 10)
      timeout("boot start");
    `CHK("data_oe in boot", 1'h1, f_do_oe)
    n = 0;
    hi = 0;
    meas = 1'h0;
    for (t = 0; t < 6000 && bdone !== 1'h1; t++) begin
      wt(1);
      if (bvalid === 1'h1) begin
        `CHK("boot byte", exp_byte(n), bdata)
        n++;
      end
      if (f_sclk === 1'h1) begin
        hi++;
      end else if (hi > 0 && !meas) begin
        `CHK("flash half period", exp_half(r), 5'(hi))
        meas = 1'h1;
      end
    end
    if (t >= 6000)
      timeout("boot");
    `CHK("boot bytes", BOOT_BYTES, 8'(n))
    `CHK("boot header", {FLASH_READ_CMD, BOOT_ADDR}, fcmd)
    `CHK("select after boot", 1'h1, f_cs_n)
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic ack, exp_bias;
    logic [7:0] ids, idv;
    logic [15:0] d, ra;
    int t, cnt;
    reset = 1'h1;
    ce = 1'h1;
    tid_sel = 1'h0;
    fsync = 1'h0;
    scl = 1'h1;
    host_sda = 1'h1;
    rate = 2'h0;
    key = 8'h00;
    mismatches = 0;
    comparisons = 0;
    d = 16'($urandom(32'h488F49DA));
    wt(20);
    // every rate code, each boot behind a fresh reset
    for (int r = 0; r < 4; r++) begin
      boot_run(2'(r));
      $display("test boot rate %0d done", r);
    end
    // writes: good id, other id, wrong register, read bit set
    exp_bias = BIAS_RESET;
    for (int k = 0; k < 6; k++) begin
      tid_sel = k[0];
      wt(8); // let the strap synchroniser settle
      ids = k[0] ? TID_HIGH : TID_LOW;
      case (k)
        2: idv = k[0] ? TID_LOW : TID_HIGH;
        4: idv = ids | 8'h01;
        default: idv = ids;
      endcase
      ra = (k == 3) ? CFG_ADDR + 16'h0001 : CFG_ADDR;
      d = 16'($urandom);
      d[BIAS_BIT] = ~exp_bias; // always a visible change
      tw_write(idv, ra, d, ack);
      `CHK("id ack", idv === ids, ack)
      `CHK("sda pull value", 1'h0, sda_out)
      if (idv === ids && ra === CFG_ADDR)
        exp_bias = d[BIAS_BIT];
      `CHK("bias level", exp_bias, bias)
      $display("test two-wire case %0d done", k);
    end
    // bias must come back connected after a reset
    boot_run(RATE_MID);
    $display("test bias reset done");
    // frame sync edges at random spacing
    for (int k = 0; k < 4; k++) begin
      wt(1 + int'($urandom % 20));
      fsync = 1'h1;
      t = 0;
      cnt = 0;
      for (int c = 1; c <= 12; c++) begin
        wt(1);
        if (valign === 1'h1) begin
          cnt++;
          t = c;
        end
      end
      `CHK("align pulses", 1, cnt)
      `CHK("align delay", 5, t)
      fsync = 1'h0;
      wt(12);
    end
    $display("test frame sync done");
    // a low enable freezes the block, sync edge included
    ce = 1'h0;
    fsync = 1'h1;
    wt(12);
    `CHK("align while frozen", 1'h0, valign)
    ce = 1'h1;
    t = 0;
    while (valign !== 1'h1 && t < 12) begin
      wt(1);
      t++;
    end
    `CHK("align after enable", 5, t)
    if (t >= 12)
      timeout("enable");
    fsync = 1'h0;
    wt(12);
    $display("test clock enable done");
    summarize();
  end
endmodule // reset_boot_pin_control_bench
